/* bundle_pkg.sv */
// ============================================================================
// Shared constants of the bundle decoder and the syllable fetch end.
package bundle_pkg;

    // ========================================================================
    // Syllable layout.
    localparam int SYL_W       = 32;
    localparam int STOP_BIT    = 31;
    localparam int EXT_SEL_BIT = 23;
    localparam int EXT_W       = 23;
    localparam int SHORT_W     = 9;
    localparam int SHORT_LSB   = 12;
    localparam int MAX_SYL     = 4;
    localparam int ADDR_W      = 30;
    localparam int CNT_W       = 2;

    // ========================================================================
    // Operation class field, bits 30:24, and the match patterns per class.
    localparam int CLS_LSB = 24;
    localparam int CLS_W   = 7;
    localparam logic [CLS_W-1:0] EXT_MASK = 7'h7C;
    localparam logic [CLS_W-1:0] EXT_VAL  = 7'h50;
    localparam logic [CLS_W-1:0] MUL_MASK = 7'h78;
    localparam logic [CLS_W-1:0] MUL_VAL  = 7'h48;
    localparam logic [CLS_W-1:0] CF_MASK  = 7'h60;
    localparam logic [CLS_W-1:0] CF_VAL   = 7'h60;
    localparam logic [CLS_W-1:0] LS_MASK  = 7'h70;
    localparam logic [CLS_W-1:0] LS_VAL   = 7'h20;
    localparam logic LEFT_BOUND = 1'h0;

    // ========================================================================
    // Recoverable exception cause bits.
    localparam int CAUSE_W      = 7;
    localparam int CS_EXT_ODD   = 0;
    localparam int CS_MUL_EVEN  = 1;
    localparam int CS_CF_PLACE  = 2;
    localparam int CS_LS_COUNT  = 3;
    localparam int CS_TOO_LONG  = 4;
    localparam int CS_ORPHAN    = 5;
    localparam int CS_UNIT      = 6;

    // ========================================================================
    // Decoder phases.
    typedef enum logic [1:0] {
        ST_COLLECT = 2'b00,
        ST_PRE     = 2'b01,
        ST_COMMIT  = 2'b10
    } dec_state_t;

    // ========================================================================
    // Fetch end register map and status layout.
    localparam int REG_AW = 8;
    localparam logic [REG_AW-1:0] REG_PC     = 8'h00;
    localparam logic [REG_AW-1:0] REG_SYL    = 8'h04;
    localparam logic [REG_AW-1:0] REG_STATUS = 8'h08;
    localparam logic [REG_AW-1:0] REG_MASK   = 8'h0C;
    localparam logic [REG_AW-1:0] REG_CAUSE  = 8'h10;
    localparam int EV_W        = 3;
    localparam int EV_COMMIT   = 0;
    localparam int EV_EXC      = 1;
    localparam int EV_FATAL    = 2;
    localparam int ST_PEND_BIT = 8;

endpackage

/* bundle_if.sv */
`timescale 1ns/1ps
// ============================================================================
// Link between the syllable fetch end and the bundle decoder.
interface bundle_if;
    logic                                 syl_valid;
    logic                                 syl_ready;
    logic [bundle_pkg::SYL_W-1:0]         syl_data;
    logic [bundle_pkg::ADDR_W-1:0]        syl_addr;
    logic                                 commit_evt;
    logic                                 exc_evt;
    logic                                 fatal_evt;
    logic [bundle_pkg::CAUSE_W-1:0]       exc_cause;

    modport dec (
        input  syl_valid, syl_data, syl_addr,
        output syl_ready, commit_evt, exc_evt, fatal_evt, exc_cause
    );
    modport fetch (
        output syl_valid, syl_data, syl_addr,
        input  syl_ready, commit_evt, exc_evt, fatal_evt, exc_cause
    );
endinterface

/* bundle_decoder.sv */
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/1ps
module bundle_decoder #(
    parameter int SLOTS = bundle_pkg::MAX_SYL
) (
    input  wire logic                                    clk,
    input  wire logic                                    reset,
    input  wire logic                                    ce,
    bundle_if.dec                                        link,
    input  wire logic                                    unit_exc,
    input  wire logic                                    bus_err,
    output logic                                         pre_phase,
    output logic                                         commit,
    output logic                                         fatal,
    output logic [SLOTS-1:0]                             op_valid,
    output logic [SLOTS-1:0][bundle_pkg::SYL_W-1:0]      op_word,
    output logic [SLOTS-1:0][bundle_pkg::SYL_W-1:0]      op_imm
);
    localparam int W = bundle_pkg::SYL_W;

    // ========================================================================
    // State.
    bundle_pkg::dec_state_t                     state_ff;
    logic                                       ready_ff;
    logic [bundle_pkg::CNT_W-1:0]               cnt_ff;
    logic                                       too_long_ff;
    logic [SLOTS-1:0][W-1:0]                    buf_ff;
    logic [SLOTS-1:0][bundle_pkg::ADDR_W-1:0]   addr_ff;
    logic                                       pre_ff;
    logic                                       commit_ff;
    logic                                       fatal_ff;
    logic                                       exc_ff;
    logic [bundle_pkg::CAUSE_W-1:0]             cause_ff;
    logic [SLOTS-1:0]                           op_valid_ff;
    logic [SLOTS-1:0][W-1:0]                    op_word_ff;
    logic [SLOTS-1:0][W-1:0]                    op_imm_ff;

    logic                                       take;
    logic                                       last;
    logic [SLOTS-1:0]                           in_b;
    logic [SLOTS-1:0]                           is_ext;
    logic [SLOTS-1:0]                           is_op;
    logic [SLOTS-1:0]                           l_ext;
    logic [SLOTS-1:0]                           r_ext;
    logic [SLOTS-1:0]                           l_op;
    logic [SLOTS-1:0]                           r_op;
    logic [SLOTS-1:0][W-1:0]                    l_word;
    logic [SLOTS-1:0][W-1:0]                    r_word;
    logic [SLOTS-1:0][W-1:0]                    imm;
    logic [bundle_pkg::CAUSE_W-1:0]             cause;
    logic [bundle_pkg::CNT_W:0]                 n_cf;
    logic [bundle_pkg::CNT_W:0]                 n_ls;

    // Matches the class field of a syllable against a mask and value.
    function automatic logic cls_is(input logic [W-1:0] s,
                                    input logic [bundle_pkg::CLS_W-1:0] m,
                                    input logic [bundle_pkg::CLS_W-1:0] v);
        cls_is = (s[bundle_pkg::CLS_LSB +: bundle_pkg::CLS_W] & m) == v;
    endfunction

    // Builds the full immediate from an extension word and the short field.
    function automatic logic [W-1:0] long_imm(input logic [W-1:0] e,
                                              input logic [W-1:0] s);
        long_imm = {e[bundle_pkg::EXT_W-1:0], {bundle_pkg::SHORT_W{1'b0}}}
                 + {{(W-bundle_pkg::SHORT_W){1'b0}},
                    s[bundle_pkg::SHORT_LSB +: bundle_pkg::SHORT_W]};
    endfunction

    assign take = ready_ff && link.syl_valid;
    assign last = link.syl_data[bundle_pkg::STOP_BIT]
               || (cnt_ff == bundle_pkg::CNT_W'(SLOTS - 1));

    // ========================================================================
    // Per-slot classification and neighbour view.
    genvar g;
    generate
        for (g = 0; g < SLOTS; g++) begin : gen_slot
            assign in_b[g]   = (bundle_pkg::CNT_W'(g) <= cnt_ff);
            assign is_ext[g] = in_b[g] && cls_is(buf_ff[g], bundle_pkg::EXT_MASK,
                                                 bundle_pkg::EXT_VAL);
            assign is_op[g]  = in_b[g] && !is_ext[g];
            if (g > 0) begin : gen_l
                assign l_ext[g]  = is_ext[g-1];
                assign l_op[g]   = is_op[g-1];
                assign l_word[g] = buf_ff[g-1];
            end else begin : gen_l0
                assign l_ext[g]  = 1'b0;
                assign l_op[g]   = 1'b0;
                assign l_word[g] = '0;
            end
            if (g < SLOTS - 1) begin : gen_r
                assign r_ext[g]  = is_ext[g+1];
                assign r_op[g]   = is_op[g+1];
                assign r_word[g] = buf_ff[g+1];
            end else begin : gen_r0
                assign r_ext[g]  = 1'b0;
                assign r_op[g]   = 1'b0;
                assign r_word[g] = '0;
            end
        end
    endgenerate

    // Immediates and placement checks for the bundle held in the buffer.
    always_comb begin
        cause = '0;
        n_cf  = '0;
        n_ls  = '0;
        for (int i = 0; i < SLOTS; i++) begin
            if (l_ext[i] && l_word[i][bundle_pkg::EXT_SEL_BIT] != bundle_pkg::LEFT_BOUND) begin
                imm[i] = long_imm(l_word[i], buf_ff[i]);
            end else if (r_ext[i]
                         && r_word[i][bundle_pkg::EXT_SEL_BIT] == bundle_pkg::LEFT_BOUND) begin
                imm[i] = long_imm(r_word[i], buf_ff[i]);
            end else begin
                imm[i] = {{(W-bundle_pkg::SHORT_W){buf_ff[i][bundle_pkg::SHORT_LSB
                          + bundle_pkg::SHORT_W - 1]}},
                          buf_ff[i][bundle_pkg::SHORT_LSB +: bundle_pkg::SHORT_W]};
            end
            if (is_ext[i]) begin
                if (addr_ff[i][0]) begin
                    cause[bundle_pkg::CS_EXT_ODD] = 1'b1;
                end
                if (buf_ff[i][bundle_pkg::EXT_SEL_BIT] == bundle_pkg::LEFT_BOUND) begin
                    cause[bundle_pkg::CS_ORPHAN] |= !l_op[i];
                end else begin
                    cause[bundle_pkg::CS_ORPHAN] |= !r_op[i];
                end
            end
            if (is_op[i] && cls_is(buf_ff[i], bundle_pkg::MUL_MASK, bundle_pkg::MUL_VAL)
                && !addr_ff[i][0]) begin
                cause[bundle_pkg::CS_MUL_EVEN] = 1'b1;
            end
            if (is_op[i] && cls_is(buf_ff[i], bundle_pkg::CF_MASK, bundle_pkg::CF_VAL)) begin
                n_cf = n_cf + 1'b1;
                if (i != 0) begin
                    cause[bundle_pkg::CS_CF_PLACE] = 1'b1;
                end
            end
            if (is_op[i] && cls_is(buf_ff[i], bundle_pkg::LS_MASK, bundle_pkg::LS_VAL)) begin
                n_ls = n_ls + 1'b1;
            end
        end
        if (n_cf > 1) begin
            cause[bundle_pkg::CS_CF_PLACE] = 1'b1;
        end
        if (n_ls > 1) begin
            cause[bundle_pkg::CS_LS_COUNT] = 1'b1;
        end
        cause[bundle_pkg::CS_TOO_LONG] = too_long_ff;
        cause[bundle_pkg::CS_UNIT]     = unit_exc;
    end

    // ========================================================================
    // Phase sequencing and syllable collection.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_ff    <= bundle_pkg::ST_COLLECT;
            ready_ff    <= 1'b1;
            cnt_ff      <= '0;
            too_long_ff <= 1'b0;
            pre_ff      <= 1'b0;
        end else if (ce) begin
            unique case (state_ff)
                bundle_pkg::ST_COLLECT: begin
                    if (take) begin
                        if (last) begin
                            state_ff    <= bundle_pkg::ST_PRE;
                            ready_ff    <= 1'b0;
                            pre_ff      <= 1'b1;
                            too_long_ff <= !link.syl_data[bundle_pkg::STOP_BIT];
                        end else begin
                            cnt_ff <= cnt_ff + 1'b1;
                        end
                    end
                end
                bundle_pkg::ST_PRE: begin
                    pre_ff <= 1'b0;
                    if (|cause) begin
                        state_ff <= bundle_pkg::ST_COLLECT;
                        ready_ff <= 1'b1;
                        cnt_ff   <= '0;
                    end else begin
                        state_ff <= bundle_pkg::ST_COMMIT;
                    end
                end
                bundle_pkg::ST_COMMIT: begin
                    state_ff <= bundle_pkg::ST_COLLECT;
                    ready_ff <= 1'b1;
                    cnt_ff   <= '0;
                end
                default: begin
                    state_ff <= bundle_pkg::ST_COLLECT;
                    ready_ff <= 1'b1;
                    cnt_ff   <= '0;
                end
            endcase
        end
    end

    // Syllable buffer, written only while collecting.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            buf_ff  <= '0;
            addr_ff <= '0;
        end else if (ce && take) begin
            buf_ff[cnt_ff]  <= link.syl_data;
            addr_ff[cnt_ff] <= link.syl_addr;
        end
    end

    // Architectural outputs change only in the commit phase.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            op_valid_ff <= '0;
            op_word_ff  <= '0;
            op_imm_ff   <= '0;
            commit_ff   <= 1'b0;
        end else if (ce) begin
            commit_ff <= (state_ff == bundle_pkg::ST_PRE) && !(|cause);
            if (state_ff == bundle_pkg::ST_PRE && !(|cause)) begin
                op_valid_ff <= is_op;
                op_word_ff  <= buf_ff;
                op_imm_ff   <= imm;
            end
        end
    end

    // Exceptions: recoverable ones before commit, bus error only after it.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            exc_ff   <= 1'b0;
            cause_ff <= '0;
            fatal_ff <= 1'b0;
        end else if (ce) begin
            exc_ff   <= (state_ff == bundle_pkg::ST_PRE) && (|cause);
            fatal_ff <= (state_ff == bundle_pkg::ST_COMMIT) && bus_err;
            if (state_ff == bundle_pkg::ST_PRE && (|cause)) begin
                cause_ff <= cause;
            end
        end
    end

    assign link.syl_ready  = ready_ff;
    assign link.commit_evt = commit_ff;
    assign link.exc_evt    = exc_ff;
    assign link.fatal_evt  = fatal_ff;
    assign link.exc_cause  = cause_ff;
    assign pre_phase       = pre_ff;
    assign commit          = commit_ff;
    assign fatal           = fatal_ff;
    assign op_valid        = op_valid_ff;
    assign op_word         = op_word_ff;
    assign op_imm          = op_imm_ff;

endmodule

/* bundle_fetch.sv */
`timescale 1ns/1ps
// ============================================================================
// Syllable fetch end: software loads word address and syllables, the link
// delivers them one at a time, decoder events are gathered for interrupts.
module bundle_fetch (
    input  wire logic                                clk,
    input  wire logic                                reset,
    input  wire logic                                ce,
    bundle_if.fetch                                  link,
    input  wire logic [bundle_pkg::REG_AW-1:0]       sw_addr,
    input  wire logic [bundle_pkg::SYL_W-1:0]        sw_wdata,
    input  wire logic                                sw_wr,
    input  wire logic                                sw_rd,
    output logic      [bundle_pkg::SYL_W-1:0]        sw_rdata,
    output logic                                     irq
);
    localparam int W = bundle_pkg::SYL_W;

    logic                                    valid_ff;
    logic [W-1:0]                            data_ff;
    logic [bundle_pkg::ADDR_W-1:0]           pc_ff;
    logic [bundle_pkg::ADDR_W-1:0]           out_addr_ff;
    logic [bundle_pkg::EV_W-1:0]             status_ff;
    logic [bundle_pkg::EV_W-1:0]             mask_ff;
    logic [bundle_pkg::CAUSE_W-1:0]          cause_ff;
    logic [W-1:0]                            rdata_ff;
    logic                                    irq_ff;
    logic [bundle_pkg::EV_W-1:0]             ev;
    logic [bundle_pkg::EV_W-1:0]             clr;
    logic                                    accepted;

    assign accepted = valid_ff && link.syl_ready;
    assign ev  = {link.fatal_evt, link.exc_evt, link.commit_evt};
    assign clr = (sw_wr && sw_addr == bundle_pkg::REG_STATUS)
               ? sw_wdata[bundle_pkg::EV_W-1:0] : '0;

    // ========================================================================
    // Syllable offer; software writes to PC and SYL while one is pending are ignored.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            valid_ff    <= 1'b0;
            data_ff     <= '0;
            pc_ff       <= '0;
            out_addr_ff <= '0;
        end else if (ce) begin
            if (accepted) begin
                valid_ff <= 1'b0;
                pc_ff    <= pc_ff + 1'b1;
            end else if (!valid_ff && sw_wr && sw_addr == bundle_pkg::REG_SYL) begin
                valid_ff    <= 1'b1;
                data_ff     <= sw_wdata;
                out_addr_ff <= pc_ff;
            end else if (!valid_ff && sw_wr && sw_addr == bundle_pkg::REG_PC) begin
                pc_ff <= sw_wdata[bundle_pkg::ADDR_W-1:0];
            end
        end
    end

    // Sticky events, set wins over a write-one clear; mask and last cause.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            status_ff <= '0;
            mask_ff   <= '0;
            cause_ff  <= '0;
            irq_ff    <= 1'b0;
        end else if (ce) begin
            status_ff <= (status_ff & ~clr) | ev;
            irq_ff    <= |(((status_ff & ~clr) | ev) & mask_ff);
            if (sw_wr && sw_addr == bundle_pkg::REG_MASK) begin
                mask_ff <= sw_wdata[bundle_pkg::EV_W-1:0];
                irq_ff  <= |(((status_ff & ~clr) | ev) & sw_wdata[bundle_pkg::EV_W-1:0]);
            end
            if (link.exc_evt) begin
                cause_ff <= link.exc_cause;
            end
        end
    end

    // Read data stand in the cycle after the read strobe only.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_ff <= '0;
        end else if (ce) begin
            rdata_ff <= '0;
            if (sw_rd) begin
                unique case (sw_addr)
                    bundle_pkg::REG_PC:     rdata_ff <= W'(pc_ff);
                    bundle_pkg::REG_SYL:    rdata_ff <= data_ff;
                    bundle_pkg::REG_STATUS: rdata_ff <= W'({valid_ff,
                        {(bundle_pkg::ST_PEND_BIT - bundle_pkg::EV_W){1'b0}}, status_ff});
                    bundle_pkg::REG_MASK:   rdata_ff <= W'(mask_ff);
                    bundle_pkg::REG_CAUSE:  rdata_ff <= W'(cause_ff);
                    default:                rdata_ff <= '0;
                endcase
            end
        end
    end

    assign link.syl_valid = valid_ff;
    assign link.syl_data  = data_ff;
    assign link.syl_addr  = out_addr_ff;
    assign sw_rdata       = rdata_ff;
    assign irq            = irq_ff;

endmodule

/* bundle_chk.sv */
`timescale 1ns/1ps
// ========================================
// Checker of the syllable link.
module bundle_chk (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        syl_valid,
    input wire logic        syl_ready,
    input wire logic [31:0] syl_data,
    input wire logic [29:0] syl_addr,
    input wire logic        commit_evt,
    input wire logic        exc_evt,
    input wire logic        fatal_evt,
    input wire logic [6:0]  exc_cause
);
    logic [2:0]      cnt_ff;
    logic            ext_ff;
    logic            mul_ff;
    wire logic       take = syl_valid && syl_ready;
    wire logic       done = commit_evt || exc_evt;
    wire logic [6:0] cls  = syl_data[30:24];
    // Counts takes of a bundle and notes misplaced syllables in it.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_ff <= 3'h0;
            ext_ff <= 1'h0;
            mul_ff <= 1'h0;
        end else begin
            cnt_ff <= syl_ready ? cnt_ff + {2'h0, take} : 3'h0;
            ext_ff <= (ext_ff && !done) || (take && syl_addr[0]
                      && (cls & bundle_pkg::EXT_MASK) == bundle_pkg::EXT_VAL);
            mul_ff <= (mul_ff && !done) || (take && !syl_addr[0]
                      && (cls & bundle_pkg::MUL_MASK) == bundle_pkg::MUL_VAL);
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_last;
        take && (syl_data[31] || cnt_ff == 3'h3);
    endsequence
    sequence s_quiet;
        !done && !syl_ready;
    endsequence
    a_stop_closes: assert property (take && syl_data[31] |=> !syl_ready)
        else $error("Ready stayed high after a stop syllable.");
    a_four_limit: assert property (take && cnt_ff == 3'h3 |=> !syl_ready)
        else $error("A fifth syllable could join a bundle.");
    a_pre_quiet: assert property (s_last |=> s_quiet ##1 commit_evt != exc_evt)
        else $error("Bundle outcome out of step.");
    a_commit_pulse: assert property (commit_evt |=> !commit_evt)
        else $error("Commit lasted more than a cycle.");
    a_fatal_late: assert property (fatal_evt |-> $past(commit_evt))
        else $error("Bus error seen without a commit before it.");
    a_cause_set: assert property (exc_evt |-> exc_cause != 7'h00)
        else $error("Exception carried no cause.");
    a_cause_hold: assert property (!exc_evt |-> $stable(exc_cause))
        else $error("Cause changed without an exception.");
    a_ext_even: assert property (done && ext_ff |-> exc_evt && exc_cause[0])
        else $error("Extension at odd address not refused.");
    a_mul_odd: assert property (done && mul_ff |-> exc_evt && exc_cause[1])
        else $error("Multiply at even address not refused.");
endmodule

/* tb.sv */
`timescale 1ns/1ps
// ========================================
// Bench joining the fetch end to the decoder.
module tb;
    logic             clk;
    logic             reset;
    logic             ce;
    logic             unit_exc;
    logic             bus_err;
    logic             sw_wr;
    logic             sw_rd;
    logic             irq;
    logic             commit;
    logic             fatal;
    logic             pre_phase;
    logic [7:0]       sw_addr;
    logic [31:0]      sw_wdata;
    logic [31:0]      sw_rdata;
    logic [3:0]       op_valid;
    logic [3:0][31:0] op_word;
    logic [3:0][31:0] op_imm;
    int               err_total;
    int               samples_checked;
    int               cyc;
    bundle_if bundle_if_i ();
    bundle_decoder bundle_decoder_i (.clk(clk), .reset(reset), .ce(ce), .link(bundle_if_i),
        .unit_exc(unit_exc), .bus_err(bus_err), .pre_phase(pre_phase), .commit(commit),
        .fatal(fatal), .op_valid(op_valid), .op_word(op_word), .op_imm(op_imm));
    bundle_fetch bundle_fetch_i (.clk(clk), .reset(reset), .ce(ce), .link(bundle_if_i),
        .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
        .sw_rdata(sw_rdata), .irq(irq));
    bundle_chk bundle_chk_i (.clk(clk), .reset(reset), .syl_valid(bundle_if_i.syl_valid),
        .syl_ready(bundle_if_i.syl_ready), .syl_data(bundle_if_i.syl_data),
        .syl_addr(bundle_if_i.syl_addr), .commit_evt(bundle_if_i.commit_evt),
        .exc_evt(bundle_if_i.exc_evt), .fatal_evt(bundle_if_i.fatal_evt),
        .exc_cause(bundle_if_i.exc_cause));
    // Compares one value and counts the outcome.
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        sw_addr  <= a;
        sw_wdata <= d;
        sw_wr    <= 1'h1;
        @(posedge clk);
        sw_wr <= 1'h0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        sw_addr <= a;
        sw_rd   <= 1'h1;
        @(posedge clk);
        sw_rd <= 1'h0;
        #1;
        check(sw_rdata, exp);
    endtask
    // Loads a bundle, waits for each take and then for the outcome.
    task automatic run(input logic [29:0] pc, input int n, input logic [31:0] w [4]);
        int k;
        wr(bundle_pkg::REG_PC, {2'h0, pc});
        for (int i = 0; i < n; i++) begin
            wr(bundle_pkg::REG_SYL, w[i]);
            k = 0;
            #1;
            while (bundle_if_i.syl_valid === 1'h1 && k < 20) begin
                @(posedge clk);
                #1;
                k++;
            end
        end
        check({31'h0, pre_phase}, 32'h1);
        k = 0;
        while (commit !== 1'h1 && bundle_if_i.exc_evt !== 1'h1 && k < 20) begin
            @(posedge clk);
            #1;
            k++;
        end
        check({31'h0, k < 20}, 32'h1);
    endtask
    task automatic s_imm();
        wr(bundle_pkg::REG_MASK, 32'h7);
        bus_err <= 1'h1;
        run(30'h0, 2, '{32'h50812345, 32'h801FF000, 32'h0, 32'h0});
        check({31'h0, commit}, 32'h1);
        check({28'h0, op_valid}, 32'h2);
        check(op_imm[1], 32'h02468BFF);
        check(op_word[1], 32'h801FF000);
        @(posedge clk);
        bus_err <= 1'h0;
        #1;
        check({31'h0, fatal}, 32'h1);
        rd_chk(bundle_pkg::REG_STATUS, 32'h5);
        check({31'h0, irq}, 32'h1);
        wr(bundle_pkg::REG_STATUS, 32'h5);
        rd_chk(bundle_pkg::REG_STATUS, 32'h0);
        check({31'h0, irq}, 32'h0);
    endtask
    // A syllable written while the clock enable is low must not be offered.
    task automatic s_left_sext();
        @(posedge clk);
        ce <= 1'h0;
        wr(bundle_pkg::REG_SYL, 32'h80000000);
        ce <= 1'h1;
        rd_chk(bundle_pkg::REG_STATUS, 32'h0);
        run(30'h1, 2, '{32'h00001000, 32'hD07FFFFF, 32'h0, 32'h0});
        check({28'h0, op_valid}, 32'h1);
        check(op_imm[0], 32'hFFFFFE01);
        run(30'h5, 1, '{32'h80100000, 32'h0, 32'h0, 32'h0});
        check({28'h0, op_valid}, 32'h1);
        check(op_imm[0], 32'hFFFFFF00);
    endtask
    // Each row breaks one placement, length or unit rule; the bundle must be dropped.
    task automatic s_faults();
        logic [31:0] tw [7][4];
        logic [29:0] pc [7];
        int          n [7];
        logic [6:0]  cs [7];
        tw = '{'{32'h0, 32'hD0000000, 32'h0, 32'h0}, '{32'hC8000000, 32'h0, 32'h0, 32'h0},
               '{32'h0, 32'hE0000000, 32'h0, 32'h0}, '{32'h20000000, 32'hA0000000, 32'h0, 32'h0},
               '{32'h0, 32'h0, 32'h0, 32'h0}, '{32'hD0000000, 32'h0, 32'h0, 32'h0},
               '{32'h80000000, 32'h0, 32'h0, 32'h0}};
        pc = '{30'h0, 30'h0, 30'h1, 30'h1, 30'h1, 30'h0, 30'h1};
        n  = '{2, 1, 2, 2, 4, 1, 1};
        cs = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h40};
        wr(bundle_pkg::REG_STATUS, 32'h7);
        wr(bundle_pkg::REG_MASK, 32'h1);
        for (int i = 0; i < 7; i++) begin
            @(posedge clk);
            unit_exc <= (i == 6);
            run(pc[i], n[i], tw[i]);
            check({31'h0, bundle_if_i.exc_evt}, 32'h1);
            check({25'h0, bundle_if_i.exc_cause}, {25'h0, cs[i]});
            check(op_imm[0], 32'hFFFFFF00);
        end
        unit_exc <= 1'h0;
        rd_chk(bundle_pkg::REG_CAUSE, 32'h40);
        check({31'h0, irq}, 32'h0);
        wr(bundle_pkg::REG_MASK, 32'h2);
        rd_chk(bundle_pkg::REG_STATUS, 32'h2);
        check({31'h0, irq}, 32'h1);
        rd_chk(8'h40, 32'h0);
    endtask
    task automatic test_done();
        if (err_total == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end
    // Cuts a hang short.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            test_done();
        end
    end
    initial begin
        {reset, ce, unit_exc, bus_err, sw_wr, sw_rd} = 6'h30;
        sw_addr = 8'h0;
        sw_wdata = 32'h0;
        err_total = 0;
        samples_checked = 0;
        cyc = 0;
        repeat (5) @(posedge clk);
        reset <= 1'h0;
        s_imm();
        s_left_sext();
        s_faults();
        test_done();
    end
endmodule
